/* File: logic/pic_regs.vh */
// pic_regs.vh: register offsets, bit positions, reset values and vectors
// assumes: included by the interrupt controller design files only
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

// ============================================================
// apb byte offsets
`define PIC_OFS_MAIN 12'h000
`define PIC_OFS_EDGE 12'h004
`define PIC_OFS_EXT 12'h008
`define PIC_OFS_PFL1 12'h00c
`define PIC_OFS_RCTL 12'h010
`define PIC_OFS_PEN1 12'h014
`define PIC_OFS_PPR1 12'h018
`define PIC_OFS_STAT 12'h01c

// ============================================================
// main control bits
`define PIC_MAIN_GHE 7
`define PIC_MAIN_PLE 6
`define PIC_MAIN_T0E 5
`define PIC_MAIN_X0E 4
`define PIC_MAIN_PCE 3
`define PIC_MAIN_T0F 2
`define PIC_MAIN_X0F 1
`define PIC_MAIN_PCF 0

// edge / priority control bits
`define PIC_EDGE_X0S 6
`define PIC_EDGE_X3S 3
`define PIC_EDGE_T0P 2
`define PIC_EDGE_X3P 1
`define PIC_EDGE_PCP 0

// external pin control bits
`define PIC_EXT_X2P 7
`define PIC_EXT_X1P 6
`define PIC_EXT_X1E 3
`define PIC_EXT_X1F 0

// peripheral flags one bits
`define PIC_PF_PSP 7
`define PIC_PF_ADC 6
`define PIC_PF_RXF 5
`define PIC_PF_TXE 4
`define PIC_PF_SSP 3
`define PIC_PF_CCP 2

// reset control bit
`define PIC_RCTL_PME 7

// ============================================================
// reset values
`define PIC_RST_MAIN 8'h00
`define PIC_RST_EDGE 8'hff
`define PIC_RST_EXT 8'hc0
`define PIC_RST_PF 8'h00
`define PIC_RST_RCTL 8'h00

// vectors
`define PIC_VEC_HIGH 24'h000008
`define PIC_VEC_LOW 24'h000018

`endif

/* File: logic/pic_edge_det.v */
// pic_edge_det.v: edge detector for the four external pins and the port change
// assumes: pins are synchronous to clk
`timescale 1ns/1ns
`include "pic_regs.vh"

module pic_edge_det (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    input wire clk_en,
    // external pins
    input wire [3:0] ext_pins,
    input wire [3:0] edge_sel,
    output wire [3:0] ext_event,
    // upper port pins
    input wire [3:0] upper_port_pins,
    input wire port_read,
    output wire port_mismatch
);

// ============================================================
// pin edges
reg [3:0] pin_q;
reg [3:0] latch_q;

genvar i;
generate
    for (i = 0; i < 4; i = i + 1) begin : g_pin
        assign ext_event[i] = edge_sel[i] ? (ext_pins[i] & ~pin_q[i])
                                          : (~ext_pins[i] & pin_q[i]);
    end
endgenerate

// a port read reloads the compared value, ending the mismatch
assign port_mismatch = |(upper_port_pins ^ latch_q);

always @(posedge clk) begin
    if (sys_rst) begin
        pin_q <= 4'h0;
        latch_q <= 4'h0;
    end else if (clk_en) begin
        pin_q <= ext_pins;
        if (port_read) begin
            latch_q <= upper_port_pins;
        end
    end
end

endmodule

/* File: logic/pic_vector_sel.v */
// pic_vector_sel.v: combines flags, enables and priorities into requests
// assumes: inputs come from registers of the controller or from constants such as is_periph
`timescale 1ns/1ns
`include "pic_regs.vh"

module pic_vector_sel (
    // inputs
    input wire [11:0] flags,
    input wire [11:0] enables,
    input wire [11:0] prio,
    input wire [11:0] is_periph,
    input wire prio_mode,
    input wire glob_high,
    input wire per_low,
    // requests
    output wire req_high,
    output wire req_low
);

wire [11:0] pend;
assign pend = flags & enables;

// compatibility: all to high vector, peripherals also need the peripheral gate
wire compat_req;
assign compat_req = glob_high & (|(pend & ~is_periph) | (per_low & |(pend & is_periph)));

// priority mode: high sources gated by bit 7, low ones by bit 6
wire prio_high;
wire prio_low;
assign prio_high = glob_high & |(pend & prio);
// bit 7 low blocks every level, so low requests need both enables
assign prio_low = glob_high & per_low & |(pend & ~prio);

assign req_high = prio_mode ? prio_high : compat_req;
assign req_low = prio_mode ? prio_low : 1'b0;

endmodule

/* File: logic/pic_intc.v */
// pic_intc.v: prioritized interrupt controller, apb register slave and
// vector request logic for the core
// assumes: single 100 MHz clock, peripheral events are one-cycle pulses or
// levels synchronous to clk, the core acknowledges vectors with a pulse
`timescale 1ns/1ns
`include "pic_regs.vh"

module pic_intc (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    input wire clk_en,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // interrupt sources
    input wire timer0_overflow,
    input wire [3:0] ext_pins,
    input wire [3:0] upper_port_pins,
    input wire port_b_read,
    input wire parallel_port_event,
    input wire converter_done,
    input wire serial_rx_full,
    input wire serial_tx_empty,
    input wire sync_serial_done,
    input wire capcomp1_event,
    input wire [1:0] periph_low_flags,
    // core side
    input wire vector_ack,
    input wire return_from_interrupt,
    output reg vector_req,
    output reg [23:0] vector_addr,
    output reg in_high_service,
    output reg in_low_service
);

// ============================================================
// registers
reg [7:0] main_q;
reg [7:0] edge_q;
reg [7:0] ext_q;
reg [7:0] pf_q;
reg [7:0] rctl_q;
reg [7:0] pen_q;
reg [7:0] ppr_q;

// service states, one-hot
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_LOW = 3'b010;
localparam [2:0] ST_HIGH = 3'b100;
reg [2:0] state_q;
// a high routine entered from low returns to low
reg nested_q;

// ============================================================
// apb decode
wire acc;
wire wr;
wire rd;
assign acc = psel & penable & ~pready;
assign wr = acc & pwrite;
assign rd = acc & ~pwrite;

function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
        hit = (a == ofs);
    end
endfunction

wire wr_main;
wire wr_edge;
wire wr_ext;
wire wr_pf;
assign wr_main = wr & hit(paddr, `PIC_OFS_MAIN);
assign wr_edge = wr & hit(paddr, `PIC_OFS_EDGE);
assign wr_ext = wr & hit(paddr, `PIC_OFS_EXT);
assign wr_pf = wr & hit(paddr, `PIC_OFS_PFL1);
wire mapped;
assign mapped = hit(paddr, `PIC_OFS_MAIN) | hit(paddr, `PIC_OFS_EDGE) |
                hit(paddr, `PIC_OFS_EXT) | hit(paddr, `PIC_OFS_PFL1) |
                hit(paddr, `PIC_OFS_RCTL) | hit(paddr, `PIC_OFS_PEN1) |
                hit(paddr, `PIC_OFS_PPR1) | hit(paddr, `PIC_OFS_STAT);

// ============================================================
// edge detection
wire [3:0] ext_event;
wire port_mismatch;
// edge select bits: pin0 at bit 6 down to pin3 at bit 3
wire [3:0] edge_sel;
assign edge_sel = {edge_q[`PIC_EDGE_X3S], edge_q[`PIC_EDGE_X3S + 1],
                   edge_q[`PIC_EDGE_X3S + 2], edge_q[`PIC_EDGE_X0S]};

pic_edge_det u_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .ext_pins(ext_pins),
    .edge_sel(edge_sel),
    .ext_event(ext_event),
    .upper_port_pins(upper_port_pins),
    .port_read(port_b_read),
    .port_mismatch(port_mismatch)
);

// ============================================================
// flag update: set wins over a software clear
reg [7:0] main_d;
reg [7:0] ext_d;
reg [7:0] pf_d;
reg [7:0] set_main;
reg [7:0] set_ext;
reg [7:0] set_pf;

always @* begin
    set_main = 8'h00;
    set_main[`PIC_MAIN_T0F] = timer0_overflow;
    set_main[`PIC_MAIN_X0F] = ext_event[0];
    set_main[`PIC_MAIN_PCF] = port_mismatch;
    set_ext = 8'h00;
    set_ext[`PIC_EXT_X1F + 2:`PIC_EXT_X1F] = ext_event[3:1];
    set_pf = 8'h00;
    set_pf[`PIC_PF_PSP] = parallel_port_event;
    set_pf[`PIC_PF_ADC] = converter_done;
    set_pf[`PIC_PF_SSP] = sync_serial_done;
    set_pf[`PIC_PF_CCP] = capcomp1_event;
    set_pf[1:0] = periph_low_flags;

    main_d = wr_main ? pwdata[7:0] : main_q;
    ext_d = wr_ext ? pwdata[7:0] : ext_q;
    pf_d = wr_pf ? pwdata[7:0] : pf_q;
    main_d = main_d | set_main;
    ext_d = ext_d | set_ext;
    pf_d = pf_d | set_pf;
    // read-only flags track the buffers
    pf_d[`PIC_PF_RXF] = serial_rx_full;
    pf_d[`PIC_PF_TXE] = serial_tx_empty;

    // taking a vector drops the applicable global enable
    if (vector_req & vector_ack) begin
        if (vector_addr == `PIC_VEC_LOW) begin
            main_d[`PIC_MAIN_PLE] = 1'b0;
        end else begin
            main_d[`PIC_MAIN_GHE] = 1'b0;
        end
    end else if (return_from_interrupt) begin
        if (state_q == ST_LOW) begin
            main_d[`PIC_MAIN_PLE] = 1'b1;
        end else begin
            main_d[`PIC_MAIN_GHE] = 1'b1;
        end
    end
end

// ============================================================
// request combine
wire prio_mode;
assign prio_mode = rctl_q[`PIC_RCTL_PME];
wire [11:0] flags;
wire [11:0] enables;
wire [11:0] prio;
// bit order: t0, x0, pc, x3, x2, x1, psp, adc, rx, tx, ssp, ccp; the low two pf bits are left out
assign flags = {main_q[`PIC_MAIN_T0F], main_q[`PIC_MAIN_X0F], main_q[`PIC_MAIN_PCF],
                ext_q[2:0], pf_q[7:2]};
assign enables = {main_q[`PIC_MAIN_T0E], main_q[`PIC_MAIN_X0E], main_q[`PIC_MAIN_PCE],
                  ext_q[5:3], pen_q[7:2]};
// pin 0 is always high priority
assign prio = {edge_q[`PIC_EDGE_T0P], 1'b1, edge_q[`PIC_EDGE_PCP],
               edge_q[`PIC_EDGE_X3P], ext_q[`PIC_EXT_X2P], ext_q[`PIC_EXT_X1P],
               ppr_q[7:2]};
wire req_high;
wire req_low;

pic_vector_sel u_sel (
    .flags(flags),
    .enables(enables),
    .prio(prio),
    .is_periph(12'h03f),
    .prio_mode(prio_mode),
    .glob_high(main_q[`PIC_MAIN_GHE]),
    .per_low(main_q[`PIC_MAIN_PLE]),
    .req_high(req_high),
    .req_low(req_low)
);

// ============================================================
// register and service state
always @(posedge clk) begin
    if (sys_rst) begin
        main_q <= `PIC_RST_MAIN;
        edge_q <= `PIC_RST_EDGE;
        ext_q <= `PIC_RST_EXT;
        pf_q <= `PIC_RST_PF;
        rctl_q <= `PIC_RST_RCTL;
        pen_q <= 8'h00;
        ppr_q <= 8'hff;
        state_q <= ST_IDLE;
        nested_q <= 1'b0;
        vector_req <= 1'b0;
        vector_addr <= `PIC_VEC_HIGH;
        in_high_service <= 1'b0;
        in_low_service <= 1'b0;
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else if (clk_en) begin
        main_q <= main_d;
        ext_q <= ext_d;
        pf_q <= pf_d;
        if (wr_edge) begin
            edge_q <= pwdata[7:0];
        end
        if (wr & hit(paddr, `PIC_OFS_RCTL)) begin
            rctl_q <= pwdata[7:0];
        end
        if (wr & hit(paddr, `PIC_OFS_PEN1)) begin
            pen_q <= pwdata[7:0];
        end
        if (wr & hit(paddr, `PIC_OFS_PPR1)) begin
            ppr_q <= pwdata[7:0];
        end

        // apb answers one cycle into the access phase
        pready <= acc;
        pslverr <= acc & ~mapped;
        if (rd) begin
            case (paddr)
                `PIC_OFS_MAIN: prdata <= {24'h000000, main_q};
                `PIC_OFS_EDGE: prdata <= {24'h000000, edge_q};
                `PIC_OFS_EXT: prdata <= {24'h000000, ext_q};
                `PIC_OFS_PFL1: prdata <= {24'h000000, pf_q};
                `PIC_OFS_RCTL: prdata <= {24'h000000, rctl_q};
                `PIC_OFS_PEN1: prdata <= {24'h000000, pen_q};
                `PIC_OFS_PPR1: prdata <= {24'h000000, ppr_q};
                `PIC_OFS_STAT: prdata <= {29'h00000000, port_mismatch,
                                          in_high_service, in_low_service};
                default: prdata <= 32'h00000000;
            endcase
        end

        // vector request; high may preempt low service
        if (vector_req & vector_ack) begin
            vector_req <= 1'b0;
            if (vector_addr == `PIC_VEC_LOW) begin
                state_q <= ST_LOW;
            end else begin
                nested_q <= (state_q == ST_LOW);
                state_q <= ST_HIGH;
            end
        end else if (return_from_interrupt) begin
            vector_req <= 1'b0;
            case (state_q)
                ST_HIGH: begin
                    state_q <= nested_q ? ST_LOW : ST_IDLE;
                    nested_q <= 1'b0;
                end
                ST_LOW: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end else begin
            case (state_q)
                ST_IDLE: begin
                    vector_req <= req_high | req_low;
                    vector_addr <= req_high ? `PIC_VEC_HIGH : `PIC_VEC_LOW;
                end
                ST_LOW: begin
                    vector_req <= prio_mode & req_high;
                    vector_addr <= `PIC_VEC_HIGH;
                end
                ST_HIGH: vector_req <= 1'b0;
                default: state_q <= ST_IDLE;
            endcase
        end
        in_high_service <= (state_q == ST_HIGH);
        in_low_service <= (state_q == ST_LOW);
    end
end

endmodule

/* File: tb/pri_intc_properties.sv */
// checker: apb and vector handshake properties of the controller
// assumes: bound to pic_intc, clk_en held high by the bench
`timescale 1ns/1ns
module pri_intc_props (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // core side
    input wire vector_ack,
    input wire return_from_interrupt,
    input wire vector_req,
    input wire [23:0] vector_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========
    // apb answer
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
    property p_rdy_resp; psel && penable && !pready |=> pready; endproperty
    a_rdy_resp: assert property (p_rdy_resp) else $error("no pready");
    property p_err_rdy; pslverr |-> pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
    property p_rd_hi; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    // unmapped places answer with an error and zero data
    property p_unmap;
        psel && penable && !pready && paddr > 12'h01c |=> pslverr && prdata == 32'h00000000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    // ==========
    // vector handshake
    property p_ack_drop; vector_req && vector_ack |=> !vector_req; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("req after ack");
    property p_req_hold;
        vector_req && !vector_ack && !return_from_interrupt |=> vector_req;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("req withdrawn");
    property p_vec;
        vector_req |-> vector_addr == 24'h000008 || vector_addr == 24'h000018;
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_rst;
        @(posedge clk) disable iff (1'b0)
        sys_rst |=> !pready && !vector_req && vector_addr == 24'h000008;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    c_low: cover property (vector_req && vector_ack && vector_addr == 24'h000018);
    c_high: cover property (vector_req && vector_ack && vector_addr == 24'h000008);
    c_err: cover property (pslverr);
endmodule
bind pic_intc pri_intc_props i_pri_intc_props (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vector_ack(vector_ack),
    .return_from_interrupt(return_from_interrupt),
    .vector_req(vector_req), .vector_addr(vector_addr)
);

/* File: tb/pri_core_model.sv */
// core model: takes vector requests after a set delay, returns on command
// assumes: shares clk and sys_rst with the controller
`timescale 1ns/1ns
module pri_core_model (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // bench control
    input wire [3:0] ack_delay,
    input wire ret_go,
    // controller side
    input wire vector_req,
    output logic vector_ack,
    output logic return_from_interrupt
);
    logic [3:0] cnt_q;
    // ack only while a request stands, and only once per request
    always @(posedge clk) begin
        if (sys_rst || !vector_req || vector_ack) begin
            cnt_q <= 4'h0;
            vector_ack <= 1'b0;
        end else if (cnt_q == ack_delay) begin
            vector_ack <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    always @(posedge clk) return_from_interrupt <= ret_go & ~sys_rst;
endmodule

/* File: tb/tb_top.sv */
// bench: flags, registers and vectoring of the controller over apb
// assumes: core model beside the design, checker bound to the design
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {
        logic [3:0] b;
        logic [11:0] a;
        logic [7:0] e;
        logic [7:0] z;
    } pri_row_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [12:0] ev = 13'h0000;
    logic [3:0] up = 4'h0;
    logic pbr = 1'b0;
    logic ret_go = 1'b0;
    logic [3:0] ack_dly = 4'h2;
    logic lerr;
    wire [31:0] prdata;
    wire pready, pslverr, vack, rfi, vreq, ihs, ils;
    wire [23:0] vaddr;
    int err_count = 0;
    int total_checks = 0;
    pri_row_t rows [13] = '{
        '{4'd0, 12'h000, 8'h04, 8'h00},
        '{4'd1, 12'h000, 8'h02, 8'h00},
        '{4'd2, 12'h008, 8'hc1, 8'hc0},
        '{4'd3, 12'h008, 8'hc2, 8'hc0},
        '{4'd4, 12'h008, 8'hc4, 8'hc0},
        '{4'd5, 12'h00c, 8'h80, 8'h00},
        '{4'd6, 12'h00c, 8'h40, 8'h00},
        '{4'd7, 12'h00c, 8'h08, 8'h00},
        '{4'd8, 12'h00c, 8'h04, 8'h00},
        '{4'd9, 12'h00c, 8'h20, 8'h00},
        '{4'd10, 12'h00c, 8'h10, 8'h00},
        '{4'd11, 12'h00c, 8'h01, 8'h00},
        '{4'd12, 12'h00c, 8'h02, 8'h00}
    };
    always #5 clk = ~clk;
    pic_intc i_pic_intc (
        .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer0_overflow(ev[0]), .ext_pins(ev[4:1]), .upper_port_pins(up),
        .port_b_read(pbr), .parallel_port_event(ev[5]), .converter_done(ev[6]),
        .serial_rx_full(ev[9]), .serial_tx_empty(ev[10]), .sync_serial_done(ev[7]),
        .capcomp1_event(ev[8]), .periph_low_flags(ev[12:11]),
        .vector_ack(vack), .return_from_interrupt(rfi), .vector_req(vreq),
        .vector_addr(vaddr), .in_high_service(ihs), .in_low_service(ils)
    );
    pri_core_model i_pri_core_model (
        .clk(clk), .sys_rst(sys_rst), .ack_delay(ack_dly), .ret_go(ret_go),
        .vector_req(vreq), .vector_ack(vack), .return_from_interrupt(rfi)
    );
    // ==========
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, seen, exp);
        end
    endtask
    // entered just after a rising edge; holds the request until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] r);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        r = prdata;
        lerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] r;
        apb(1'b0, a, 8'h00, r);
        chk(r, {24'h000000, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse(input int b);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev[b] <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ret();
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
        cyc(3);
    endtask
    task automatic port_read();
        pbr <= 1'b1;
        @(posedge clk);
        pbr <= 1'b0;
        wr(12'h000, 8'h00);
    endtask
    // waits for a request, checks its vector, then waits for the ack to land
    task automatic wreq(input logic [23:0] ea);
        int n;
        n = 0;
        while (vreq !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk({7'h00, vreq, vaddr}, {8'h01, ea});
        while (vreq === 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        cyc(2);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ==========
    // sequence
    initial begin
        cyc(8);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(12'h000, 8'h00);
        rd(12'h004, 8'hff);
        rd(12'h008, 8'hc0);
        rd(12'h00c, 8'h00);
        rd(12'h010, 8'h00);
        rd(12'h018, 8'hff);
        rd(12'h020, 8'h00);
        chk({31'h0, lerr}, 32'h1);
        $display("done reset values");
        port_read();
        up <= 4'h9;
        cyc(2);
        wr(12'h000, 8'h00);
        rd(12'h000, 8'h01);
        port_read();
        rd(12'h000, 8'h00);
        for (int i = 0; i < 13; i++) begin
            ev[rows[i].b] <= 1'b1;
            cyc(2);
            rd(rows[i].a, rows[i].e);
            ev[rows[i].b] <= 1'b0;
            cyc(2);
            wr(rows[i].a, rows[i].z);
            rd(rows[i].a, rows[i].z);
        end
        $display("done flag table");
        // a held event must beat the clear; the receive flag ignores writes
        ev[0] <= 1'b1;
        ev[9] <= 1'b1;
        wr(12'h000, 8'h00);
        wr(12'h00c, 8'h00);
        rd(12'h000, 8'h04);
        rd(12'h00c, 8'h20);
        ev[0] <= 1'b0;
        ev[9] <= 1'b0;
        cyc(2);
        wr(12'h000, 8'h00);
        wr(12'h004, 8'hbf);
        ev[1] <= 1'b1;
        cyc(3);
        rd(12'h000, 8'h00);
        ev[1] <= 1'b0;
        cyc(3);
        rd(12'h000, 8'h02);
        wr(12'h004, 8'hff);
        wr(12'h000, 8'he0);
        pulse(0);
        wreq(24'h000008);
        rd(12'h000, 8'h64);
        wr(12'h000, 8'h60);
        ret();
        rd(12'h000, 8'he0);
        wr(12'h000, 8'h60);
        pulse(0);
        cyc(4);
        chk({31'h0, vreq}, 32'h0);
        wr(12'h000, 8'h00);
        wr(12'h014, 8'h40);
        wr(12'h000, 8'h80);
        pulse(6);
        cyc(4);
        chk({31'h0, vreq}, 32'h0);
        ack_dly <= 4'ha;
        wr(12'h000, 8'hc0);
        wreq(24'h000008);
        wr(12'h00c, 8'h00);
        ret();
        wr(12'h010, 8'h80);
        wr(12'h018, 8'hbf);
        wr(12'h000, 8'he0);
        pulse(6);
        wreq(24'h000018);
        chk({30'h0, ihs, ils}, 32'h1);
        pulse(0);
        wreq(24'h000008);
        chk({30'h0, ihs, ils}, 32'h2);
        rd(12'h01c, 8'h02);
        rd(12'h000, 8'h24);
        $display("done vectors");
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        @(posedge clk);
        // pins still read 9 against a latch reset to 0: mismatch sets the flag again
        rd(12'h000, 8'h01);
        rd(12'h010, 8'h00);
        chk({31'h0, vreq}, 32'h0);
        final_report();
    end
    initial begin
        #100000;
        err_count++;
        final_report();
    end
endmodule
